// >>> rtl/mcr_pkg.sv
// Package of addresses, field positions and codes for the master control block
package mcr_pkg;

    // ********************************************************
    // Register addresses
    // ********************************************************
    localparam logic [7:0] MCR_ADDR_CONTROL = 8'hA0;
    localparam logic [7:0] MCR_ADDR_CONFIG = 8'hA1;
    localparam logic [7:0] MCR_ADDR_WAKE_STATUS = 8'h42;
    localparam logic [7:0] MCR_ADDR_LPMEM_FIRST = 8'h81;
    localparam logic [7:0] MCR_ADDR_LPMEM_LAST = 8'h90;

    // ********************************************************
    // Master control fields
    // ********************************************************
    localparam int MCR_BIT_SLOW_CLOCK_BYPASS = 7;
    localparam int MCR_BIT_STATUS_CLEAR = 6;
    localparam int MCR_BIT_RAM_ADDRESS_INVERT = 5;
    localparam int MCR_BIT_SLOW_OSC_OUTPUT_DISABLE = 4;
    localparam int MCR_BIT_RAM_DISABLE = 3;
    localparam int MCR_BIT_SYSTEM_CLOCK_OVERRIDE = 2;
    localparam int MCR_BIT_LOWPOWER_MEMORY_CLEAR = 1;
    localparam int MCR_BIT_DISPLAY_ENABLE = 0;
    localparam logic [7:0] MCR_CONTROL_RESET = 8'h00;
    // Strobe bits are never stored, so they always read back as zero
    localparam logic [7:0] MCR_CONTROL_STORE_MASK = 8'hBD;

    // ********************************************************
    // Master configuration fields
    // ********************************************************
    localparam int MCR_BIT_BANDGAP_HI = 7;
    localparam int MCR_BIT_BANDGAP_LO = 6;
    localparam int MCR_BIT_CHARGE_PUMP_BYPASS = 0;
    localparam logic [7:0] MCR_CONFIG_RESET = 8'h00;
    localparam logic [1:0] MCR_BANDGAP_NORMAL = 2'h0;
    localparam logic [1:0] MCR_BANDGAP_RESERVED = 2'h1;
    localparam logic [1:0] MCR_BANDGAP_LOW_LOOSE = 2'h2;
    localparam logic [1:0] MCR_BANDGAP_LOW_TIGHT = 2'h3;

    // ********************************************************
    // Wake status and low-power memory
    // ********************************************************
    localparam int MCR_WAKE_FLAGS = 3;
    localparam logic [2:0] MCR_WAKE_RESET = 3'h0;
    localparam int MCR_LPMEM_BYTES = 16;
    localparam int MCR_LPMEM_IDX_W = 4;
    localparam logic [7:0] MCR_LPMEM_CLEAR_VALUE = 8'h00;
    localparam int MCR_LPMEM_MASK_HI_BIT = 7;
    localparam int MCR_LPMEM_MASK_LO_BIT = 3;

    // ********************************************************
    // RAM address handling
    // ********************************************************
    localparam int MCR_RAM_ADDR_W = 16;
    localparam int MCR_RAM_INVERT_W = 8;
    localparam logic [7:0] MCR_READ_DEFAULT = 8'h00;

endpackage

// >>> rtl/mcr_wake_status.sv
// Sticky wake cause flags with a clear strobe
`timescale 1ns/1ps
`default_nettype none

module mcr_wake_status
    import mcr_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Wake causes and clear
    input wire logic [MCR_WAKE_FLAGS-1:0] wake_set,
    input wire logic clear,
    // Flags
    output logic [MCR_WAKE_FLAGS-1:0] status
);

    logic [MCR_WAKE_FLAGS-1:0] status_reg;
    logic [MCR_WAKE_FLAGS-1:0] status_next;

    // clear drops flags, a new cause still wins
    always_comb
    begin
        status_next = status_reg;
        if (clear)
        begin
            status_next = MCR_WAKE_RESET;
        end
        status_next = status_next | wake_set;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            status_reg <= MCR_WAKE_RESET;
        end
        else
        begin
            status_reg <= status_next;
        end
    end

    assign status = status_reg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_status_clears: assert property (clear && wake_set == MCR_WAKE_RESET |=> status == MCR_WAKE_RESET)
        else $error("wake status not cleared by strobe");
    a_status_sticky: assert property (wake_set != MCR_WAKE_RESET |=> (status & $past(wake_set)) == $past(wake_set))
        else $error("wake cause lost");

endmodule // mcr_wake_status

`default_nettype wire

// >>> rtl/mcr_lowpower_mem.sv
// Sixteen byte low-power memory with bulk clear and wake mask taps
`timescale 1ns/1ps
`default_nettype none

module mcr_lowpower_mem
    import mcr_pkg::*;
#(
    parameter int BYTES = MCR_LPMEM_BYTES
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Access
    input wire logic wr_en,
    input wire logic [MCR_LPMEM_IDX_W-1:0] wr_index,
    input wire logic [7:0] wr_data,
    input wire logic [MCR_LPMEM_IDX_W-1:0] rd_index,
    output logic [7:0] rd_data,
    // Bulk clear
    input wire logic clear,
    // Wake pin masks, two per byte
    output logic [2*BYTES-1:0] wake_pin_mask
);

    logic [7:0] mem_reg [BYTES];
    logic [7:0] mem_next [BYTES];

    // ********************************************************
    // Storage
    // ********************************************************
    // clear beats a write in the same cycle
    always_comb
    begin
        for (int i = 0; i < BYTES; i++)
        begin
            mem_next[i] = mem_reg[i];
            if (clear)
            begin
                mem_next[i] = MCR_LPMEM_CLEAR_VALUE;
            end
            else if (wr_en && wr_index == MCR_LPMEM_IDX_W'(i))
            begin
                mem_next[i] = wr_data;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        for (int i = 0; i < BYTES; i++)
        begin
            if (!rst_b)
            begin
                mem_reg[i] <= MCR_LPMEM_CLEAR_VALUE;
            end
            else
            begin
                mem_reg[i] <= mem_next[i];
            end
        end
    end

    assign rd_data = mem_reg[rd_index];

    // top bit of each nibble is a pin mask
    for (genvar g = 0; g < BYTES; g++)
    begin : g_mask
        assign wake_pin_mask[2*g] = mem_reg[g][MCR_LPMEM_MASK_LO_BIT];
        assign wake_pin_mask[2*g+1] = mem_reg[g][MCR_LPMEM_MASK_HI_BIT];
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    a_clear_masks_all: assert property (clear |=> wake_pin_mask == '0)
        else $error("pin masks survive memory clear");

endmodule // mcr_lowpower_mem

`default_nettype wire

// >>> rtl/mcr_master_ctrl.sv
// Master control and master configuration registers with their effects
`timescale 1ns/1ps
`default_nettype none

module mcr_master_ctrl
    import mcr_pkg::*;
#(
    parameter int RAM_ADDR_W = MCR_RAM_ADDR_W
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Register access from the host port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic reg_rd_en,
    output logic [7:0] reg_rd_data,
    output logic reg_rd_valid,
    // Wake cause events
    input wire logic wake_osc_fail,
    input wire logic wake_alarm,
    input wire logic wake_pin_match,
    // RAM
    input wire logic [RAM_ADDR_W-1:0] ram_addr_in,
    output logic [RAM_ADDR_W-1:0] ram_addr_out,
    output logic ram_enable,
    // Clock control
    output logic slow_clock_bypass,
    output logic slow_osc_output_enable,
    output logic system_clock_override,
    // Display and power
    output logic display_enable,
    output logic [1:0] bandgap_power_mode,
    output logic bandgap_low_power,
    output logic bandgap_tight_regulation,
    output logic charge_pump_bypass,
    // Status and low-power memory
    output logic [MCR_WAKE_FLAGS-1:0] wake_cause_status,
    output logic wake_status_clear,
    output logic lowpower_memory_clear,
    output logic [2*MCR_LPMEM_BYTES-1:0] wake_pin_mask
);

    // ********************************************************
    // Address decode
    // ********************************************************
    logic hit_control;
    logic hit_config;
    logic hit_wake;
    logic hit_lpmem;
    logic [MCR_LPMEM_IDX_W-1:0] lpmem_index;
    logic [7:0] lpmem_offset;

    always_comb
    begin
        hit_control = 1'b0;
        hit_config = 1'b0;
        hit_wake = 1'b0;
        hit_lpmem = 1'b0;
        if (reg_addr == MCR_ADDR_CONTROL)
        begin
            hit_control = 1'b1;
        end
        else if (reg_addr == MCR_ADDR_CONFIG)
        begin
            hit_config = 1'b1;
        end
        else if (reg_addr == MCR_ADDR_WAKE_STATUS)
        begin
            hit_wake = 1'b1;
        end
        else if (reg_addr >= MCR_ADDR_LPMEM_FIRST && reg_addr <= MCR_ADDR_LPMEM_LAST)
        begin
            hit_lpmem = 1'b1;
        end
    end

    assign lpmem_offset = reg_addr - MCR_ADDR_LPMEM_FIRST;
    assign lpmem_index = lpmem_offset[MCR_LPMEM_IDX_W-1:0];

    // ********************************************************
    // Control and configuration registers
    // ********************************************************
    logic [7:0] control_reg;
    logic [7:0] control_next;
    logic [7:0] config_reg;
    logic [7:0] config_next;
    logic status_clear_reg;
    logic status_clear_next;
    logic mem_clear_reg;
    logic mem_clear_next;

    always_comb
    begin
        control_next = control_reg;
        config_next = config_reg;
        status_clear_next = 1'b0;
        mem_clear_next = 1'b0;
        if (reg_wr_en && hit_control)
        begin
            control_next = reg_wr_data & MCR_CONTROL_STORE_MASK;
            // one clear pulse per write of 1
            status_clear_next = reg_wr_data[MCR_BIT_STATUS_CLEAR];
            // one memory clear pulse per write of 1
            mem_clear_next = reg_wr_data[MCR_BIT_LOWPOWER_MEMORY_CLEAR];
        end
        if (reg_wr_en && hit_config)
        begin
            // reserved bits are stored as written and read back so
            config_next = reg_wr_data;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            control_reg <= MCR_CONTROL_RESET;
            config_reg <= MCR_CONFIG_RESET;
            status_clear_reg <= 1'b0;
            mem_clear_reg <= 1'b0;
        end
        else
        begin
            control_reg <= control_next;
            config_reg <= config_next;
            status_clear_reg <= status_clear_next;
            mem_clear_reg <= mem_clear_next;
        end
    end

    // ********************************************************
    // Control effects
    // ********************************************************
    // clock pin drives the slow clock
    assign slow_clock_bypass = control_reg[MCR_BIT_SLOW_CLOCK_BYPASS];
    assign slow_osc_output_enable = !control_reg[MCR_BIT_SLOW_OSC_OUTPUT_DISABLE];
    // RAM enable is active low in the register
    assign ram_enable = !control_reg[MCR_BIT_RAM_DISABLE];
    // override beats the clock select register
    assign system_clock_override = control_reg[MCR_BIT_SYSTEM_CLOCK_OVERRIDE];
    assign display_enable = control_reg[MCR_BIT_DISPLAY_ENABLE];
    assign wake_status_clear = status_clear_reg;
    assign lowpower_memory_clear = mem_clear_reg;

    // band gap mode decode; reserved code is passed on unchanged
    assign bandgap_power_mode = config_reg[MCR_BIT_BANDGAP_HI:MCR_BIT_BANDGAP_LO];
    assign bandgap_low_power = (bandgap_power_mode == MCR_BANDGAP_LOW_LOOSE)
        || (bandgap_power_mode == MCR_BANDGAP_LOW_TIGHT);
    assign bandgap_tight_regulation = (bandgap_power_mode == MCR_BANDGAP_LOW_TIGHT);
    // charge pump bypass, display runs from the main supply
    assign charge_pump_bypass = config_reg[MCR_BIT_CHARGE_PUMP_BYPASS];

    // ********************************************************
    // RAM address inversion
    // ********************************************************
    // Registered so the RAM sees a clean address; costs one cycle of latency
    localparam logic [RAM_ADDR_W-1:0] INVERT_MASK = RAM_ADDR_W'({MCR_RAM_INVERT_W{1'b1}});
    logic [RAM_ADDR_W-1:0] ram_addr_reg;
    logic [RAM_ADDR_W-1:0] ram_addr_next;

    always_comb
    begin
        ram_addr_next = ram_addr_in;
        if (control_reg[MCR_BIT_RAM_ADDRESS_INVERT])
        begin
            ram_addr_next = ram_addr_in ^ INVERT_MASK;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            ram_addr_reg <= '0;
        end
        else
        begin
            ram_addr_reg <= ram_addr_next;
        end
    end

    assign ram_addr_out = ram_addr_reg;

    // ********************************************************
    // Wake status and low-power memory
    // ********************************************************
    logic [7:0] lpmem_rd_data;

    // wake cause flags, cleared by the strobe
    mcr_wake_status u_wake_status
    (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .wake_set({wake_osc_fail, wake_alarm, wake_pin_match}),
        .clear(status_clear_reg),
        .status(wake_cause_status)
    );

    // memory window and wake pin masks
    mcr_lowpower_mem #(
        .BYTES(MCR_LPMEM_BYTES)
    ) u_lowpower_mem
    (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .wr_en(reg_wr_en && hit_lpmem),
        .wr_index(lpmem_index),
        .wr_data(reg_wr_data),
        .rd_index(lpmem_index),
        .rd_data(lpmem_rd_data),
        .clear(mem_clear_reg),
        .wake_pin_mask(wake_pin_mask)
    );

    // ********************************************************
    // Read path
    // ********************************************************
    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;
    logic rd_valid_reg;

    always_comb
    begin
        rd_data_next = rd_data_reg;
        if (reg_rd_en)
        begin
            if (hit_control)
            begin
                rd_data_next = control_reg;
            end
            else if (hit_config)
            begin
                rd_data_next = config_reg;
            end
            else if (hit_wake)
            begin
                rd_data_next = {{(8-MCR_WAKE_FLAGS){1'b0}}, wake_cause_status};
            end
            else if (hit_lpmem)
            begin
                rd_data_next = lpmem_rd_data;
            end
            else
            begin
                rd_data_next = MCR_READ_DEFAULT;
            end
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            rd_data_reg <= MCR_READ_DEFAULT;
            rd_valid_reg <= 1'b0;
        end
        else
        begin
            rd_data_reg <= rd_data_next;
            rd_valid_reg <= reg_rd_en;
        end
    end

    assign reg_rd_data = rd_data_reg;
    assign reg_rd_valid = rd_valid_reg;

    // ********************************************************
    // Checks
    // ********************************************************
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence s_ctrl_write;
        reg_wr_en && hit_control;
    endsequence

    sequence s_single_pulse(sig);
        sig ##1 !sig;
    endsequence

    a_bypass_follows: assert property (s_ctrl_write |=> slow_clock_bypass == $past(reg_wr_data[7]))
        else $error("slow clock bypass not updated");
    a_status_clear_once: assert property (s_ctrl_write ##0 reg_wr_data[6] ##1 !reg_wr_en
        |-> s_single_pulse(wake_status_clear))
        else $error("status clear is not a single pulse");
    a_addr_invert: assert property (##1 ram_addr_out == ($past(ram_addr_in)
        ^ ($past(control_reg[5]) ? INVERT_MASK : '0)))
        else $error("RAM address inversion wrong");
    a_osc_gate: assert property (s_ctrl_write |=> slow_osc_output_enable == !$past(reg_wr_data[4]))
        else $error("oscillator gate wrong");
    a_ram_enable: assert property (s_ctrl_write |=> ram_enable == !$past(reg_wr_data[3]))
        else $error("RAM enable wrong");
    a_clock_override: assert property (s_ctrl_write |=> system_clock_override == $past(reg_wr_data[2]))
        else $error("system clock override wrong");
    a_memclr_once: assert property (s_ctrl_write ##0 reg_wr_data[1] ##1 !reg_wr_en
        |-> s_single_pulse(lowpower_memory_clear) ##0 wake_pin_mask == '0)
        else $error("memory clear pulse or effect wrong");
    a_display_enable: assert property (s_ctrl_write |=> display_enable == $past(reg_wr_data[0]))
        else $error("display enable wrong");
    a_bandgap_decode: assert property (reg_wr_en && hit_config |=> bandgap_low_power == $past(reg_wr_data[7])
        && bandgap_tight_regulation == ($past(reg_wr_data[7:6]) == MCR_BANDGAP_LOW_TIGHT))
        else $error("band gap decode wrong");
    a_pump_bypass: assert property (reg_wr_en && hit_config |=> charge_pump_bypass == $past(reg_wr_data[0]))
        else $error("charge pump bypass wrong");
    a_strobes_read_zero: assert property (reg_rd_en && hit_control |=> reg_rd_valid
        && reg_rd_data[6] == 1'b0 && reg_rd_data[1] == 1'b0)
        else $error("strobe bits read back nonzero");
    a_wake_readback: assert property (reg_rd_en && hit_wake |=> reg_rd_data[7:3] == 5'h00)
        else $error("wake status upper bits nonzero");

endmodule // mcr_master_ctrl

`default_nettype wire

// >>> bench/tb.sv
// Self-checking testbench for the master control and configuration registers
`timescale 1ns/1ps
`default_nettype none

module tb;
    import mcr_pkg::*;

    // ********************************************************
    // Signals
    // ********************************************************
    logic ref_clk;
    logic rst_b;
    logic [7:0] reg_addr;
    logic reg_wr_en;
    logic [7:0] reg_wr_data;
    logic reg_rd_en;
    logic [7:0] reg_rd_data;
    logic reg_rd_valid;
    logic wake_osc_fail;
    logic wake_alarm;
    logic wake_pin_match;
    logic [15:0] ram_addr_in;
    logic [15:0] ram_addr_out;
    logic ram_enable;
    logic slow_clock_bypass;
    logic slow_osc_output_enable;
    logic system_clock_override;
    logic display_enable;
    logic [1:0] bandgap_power_mode;
    logic bandgap_low_power;
    logic bandgap_tight_regulation;
    logic charge_pump_bypass;
    logic [2:0] wake_cause_status;
    logic wake_status_clear;
    logic lowpower_memory_clear;
    logic [31:0] wake_pin_mask;
    int fail_count = 0;
    int samples_checked = 0;
    int cycle_count = 0;
    logic [7:0] rd_val;

    mcr_master_ctrl mcr_master_ctrl_i (
        .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data(reg_rd_data),
        .reg_rd_valid(reg_rd_valid), .wake_osc_fail(wake_osc_fail), .wake_alarm(wake_alarm),
        .wake_pin_match(wake_pin_match), .ram_addr_in(ram_addr_in), .ram_addr_out(ram_addr_out),
        .ram_enable(ram_enable), .slow_clock_bypass(slow_clock_bypass),
        .slow_osc_output_enable(slow_osc_output_enable), .system_clock_override(system_clock_override),
        .display_enable(display_enable), .bandgap_power_mode(bandgap_power_mode),
        .bandgap_low_power(bandgap_low_power), .bandgap_tight_regulation(bandgap_tight_regulation),
        .charge_pump_bypass(charge_pump_bypass), .wake_cause_status(wake_cause_status),
        .wake_status_clear(wake_status_clear), .lowpower_memory_clear(lowpower_memory_clear),
        .wake_pin_mask(wake_pin_mask)
    );

    // ********************************************************
    // Clock, timeout and shared tasks
    // ********************************************************
    initial
    begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // Whole run needs well under a thousand cycles
    always @(posedge ref_clk)
    begin
        cycle_count <= cycle_count + 1;
        if (cycle_count == 3000)
        begin
            fail_count++;
            results();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    // Start and finish one cycle apart, so back-to-back calls never touch the strobe twice
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        #1 reg_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        @(posedge ref_clk);
        #1 reg_wr_en = 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        #1 reg_addr = a;
        reg_rd_en = 1'b1;
        @(posedge ref_clk);
        #1 reg_rd_en = 1'b0;
        check(reg_rd_valid, 1'b1, "read valid");
        d = reg_rd_data;
    endtask

    // ********************************************************
    // Scenarios
    // ********************************************************
    task automatic t_reset;
        check(ram_enable, 1'b1, "ram enable after reset");
        check(slow_osc_output_enable, 1'b1, "osc enable after reset");
        rd(MCR_ADDR_CONTROL, rd_val);
        check(rd_val, 8'h00, "control reset");
        rd(MCR_ADDR_CONFIG, rd_val);
        check(rd_val, 8'h00, "config reset");
        rd(8'h55, rd_val);
        check(rd_val, 8'h00, "unmapped read");
        $display("test reset done");
    endtask

    task automatic t_control;
        int bits[6] = '{7, 5, 4, 3, 2, 0};
        foreach (bits[i])
        begin
            wr(MCR_ADDR_CONTROL, 8'h01 << bits[i]);
            check(slow_clock_bypass, bits[i] == 7, "bypass");
            check(slow_osc_output_enable, bits[i] != 4, "osc gate");
            check(ram_enable, bits[i] != 3, "ram enable");
            check(system_clock_override, bits[i] == 2, "clock override");
            check(display_enable, bits[i] == 0, "display");
            rd(MCR_ADDR_CONTROL, rd_val);
            check(rd_val, 8'h01 << bits[i], "control readback");
        end
        wr(MCR_ADDR_CONTROL, 8'hFF);
        check(wake_status_clear, 1'b1, "status clear pulse");
        check(lowpower_memory_clear, 1'b1, "memory clear pulse");
        @(posedge ref_clk);
        #1 check(wake_status_clear, 1'b0, "status clear one shot");
        check(lowpower_memory_clear, 1'b0, "memory clear one shot");
        rd(MCR_ADDR_CONTROL, rd_val);
        check(rd_val, 8'hBD, "strobes read zero");
        $display("test control done");
    endtask

    task automatic t_config;
        logic [7:0] v;
        for (int c = 0; c < 4; c++)
        begin
            v = {c[1:0], 5'h00, c[0]};
            wr(MCR_ADDR_CONFIG, v);
            check(bandgap_power_mode, c[1:0], "bandgap mode");
            check(bandgap_low_power, c[1], "bandgap low power");
            check(bandgap_tight_regulation, c == 3, "bandgap tight");
            check(charge_pump_bypass, c[0], "pump bypass");
            rd(MCR_ADDR_CONFIG, rd_val);
            check(rd_val & 8'hC1, v, "config readback");
        end
        // leave band gap low loose, as before shutdown
        wr(MCR_ADDR_CONFIG, {MCR_BANDGAP_LOW_LOOSE, 6'h00});
        check(bandgap_low_power, 1'b1, "shutdown band gap low");
        check(bandgap_tight_regulation, 1'b0, "shutdown band gap loose");
        // rest of run is far shorter than one 2 ms pump interval
        $display("test config done");
    endtask

    task automatic t_wake;
        @(posedge ref_clk);
        #1 {wake_osc_fail, wake_alarm, wake_pin_match} = 3'h7;
        @(posedge ref_clk);
        #1 {wake_osc_fail, wake_alarm, wake_pin_match} = 3'h0;
        rd(MCR_ADDR_WAKE_STATUS, rd_val);
        check(rd_val, 8'h07, "wake flags set");
        wr(MCR_ADDR_WAKE_STATUS, 8'h00);
        check(wake_cause_status, 3'h7, "status ignores writes");
        wr(MCR_ADDR_CONTROL, 8'h40);
        wake_alarm = 1'b1;
        @(posedge ref_clk);
        #1 wake_alarm = 1'b0;
        check(wake_cause_status, 3'h2, "new event beats clear");
        wr(MCR_ADDR_CONTROL, 8'h40);
        @(posedge ref_clk);
        #1 check(wake_cause_status, 3'h0, "flags cleared");
        $display("test wake done");
    endtask

    task automatic t_memory;
        wr(MCR_ADDR_LPMEM_FIRST, 8'h88);
        wr(MCR_ADDR_LPMEM_LAST, 8'h80);
        rd(MCR_ADDR_LPMEM_LAST, rd_val);
        check(rd_val, 8'h80, "memory readback");
        @(posedge ref_clk);
        #1 check(wake_pin_mask, 32'h80000003, "pin masks");
        wr(MCR_ADDR_CONTROL, 8'h02);
        @(posedge ref_clk);
        #1 check(wake_pin_mask, 32'h00000000, "masks cleared");
        rd(MCR_ADDR_LPMEM_FIRST, rd_val);
        check(rd_val, 8'h00, "memory cleared");
        $display("test memory done");
    endtask

    task automatic t_ram;
        wr(MCR_ADDR_CONTROL, 8'h20);
        ram_addr_in = 16'h04A5;
        @(posedge ref_clk);
        #1 check(ram_addr_out, 16'h045A, "inverted address");
        wr(MCR_ADDR_CONTROL, 8'h00);
        @(posedge ref_clk);
        #1 check(ram_addr_out, 16'h04A5, "plain address");
        $display("test ram done");
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ********************************************************
    // Main sequence
    // ********************************************************
    initial
    begin
        rst_b = 1'b0;
        reg_addr = 8'h00;
        reg_wr_en = 1'b0;
        reg_wr_data = 8'h00;
        reg_rd_en = 1'b0;
        wake_osc_fail = 1'b0;
        wake_alarm = 1'b0;
        wake_pin_match = 1'b0;
        ram_addr_in = 16'h0000;
        repeat (16) @(posedge ref_clk);
        #1 rst_b = 1'b1;
        t_reset();
        t_control();
        t_config();
        t_wake();
        t_memory();
        t_ram();
        results();
    end

endmodule // tb

`default_nettype wire
